// >>> bench/osc_time_model.sv
/*
 Crystal stand-in: square wave of eight core cycles, stoppable.
 Assumes core_clk; the block treats it as asynchronous.
*/
`timescale 1ns/1ps
module osc_time_model
	import rtc_evt_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic osc_run,
	output logic      osc_in_pin
);
	logic [2:0] div_q = 3'h0;
	// Stopped crystal freezes at its last level, no edges
	always @(posedge core_clk)
		if (osc_run)
			div_q <= div_q + 3'h1;
	assign osc_in_pin = div_q[2];
endmodule

// >>> bench/rtc_event_block_tb.sv
/*
 Testbench for rtc_event_block: APB host, time inputs, oscillator model.
 Assumes stop detect shortened to 200 cycles, tick every 8 cycles.
*/
`timescale 1ns/1ps
module rtc_event_block_tb
	import rtc_evt_pkg::*;
;
	logic        core_clk, resetn, osc_run, ce, carry, run_en, chain, er, osc;
	logic [6:0]  minute;
	logic [5:0]  hour;
	logic [31:0] rd;
	apb_req_t    req;
	apb_rsp_t    rsp;
	od_pin_t     irq, tmr;
	int          bad_count = 0, compares = 0, cyc = 0, n, w;
	int          tk[3] = '{16, 32, 256};
	osc_time_model osc_time_model_inst (.core_clk(core_clk), .osc_run(osc_run),
		.osc_in_pin(osc));
	rtc_event_block #(.OSC_STOP_CYC(200)) rtc_event_block_inst (.core_clk(core_clk),
		.resetn(resetn), .apb_req(req), .apb_rsp(rsp), .osc_in_pin(osc),
		.chip_enable_pin(ce), .cur_minute(minute), .cur_hour(hour), .carry_in(carry),
		.irq_pin_n(irq), .timer_pulse_pin(tmr), .count_run_enable(run_en),
		.count_chain_reset(chain));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Whole run needs about 25000 cycles
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	task give_verdict();
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Idle edge at the end so back-to-back calls never reassign req at once
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do @(posedge core_clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge core_clk);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task wri(input logic [7:0] a, input logic [31:0] d, input logic e);
		xfer(1'b1, a, d);
		repeat (2) @(posedge core_clk);
		chk(irq.oe, e);
	endtask
	task wait_pin(input logic t, input logic v, input int lim, output int k);
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while ((t ? tmr.oe : irq.oe) !== v && k < lim);
	endtask
	task t_reset();
		rdchk(OFS_CTRL1, 32'h7, 32'h1);
		rdchk(OFS_CTRL2, 32'hF, 32'h8);
		xfer(1'b0, 8'h18, 32'h0);
		chk(er, 32'h1);
	endtask
	task t_init();
		carry <= 1'b1;
		xfer(1'b1, OFS_CTRL3, 32'h7);
		repeat (20) @(posedge core_clk);
		rdchk(OFS_CTRL2, 32'h4, 32'h4);
		carry <= 1'b0;
		repeat (4) @(posedge core_clk);
		rdchk(OFS_CTRL2, 32'h4, 32'h0);
		xfer(1'b1, OFS_CTRL2, 32'h0);
		rdchk(OFS_CTRL2, 32'hF, 32'h0);
		xfer(1'b1, OFS_CTRL1, 32'h4);
		chk(run_en, 32'h0);
	endtask
	task t_alarm();
		xfer(1'b1, OFS_ALARM, {18'h0, 6'h07, 1'b0, 7'h30});
		xfer(1'b1, OFS_CTRL1, 32'h2);
		minute <= 7'h30;
		hour <= 6'h07;
		repeat (3) @(posedge core_clk);
		chk(irq.oe, 32'h1);
		rdchk(OFS_CTRL2, 32'h1, 32'h1);
		wri(OFS_CTRL1, 32'h0, 1'b0);
		wri(OFS_CTRL1, 32'h2, 1'b1);
		wri(OFS_CTRL2, 32'hE, 1'b0);
	endtask
	task t_ce();
		ce <= 1'b0;
		minute <= 7'h00;
		repeat (10) @(posedge core_clk);
		chk(run_en, 32'h1);
		minute <= 7'h30;
		repeat (3) @(posedge core_clk);
		chk(irq.oe, 32'h1);
		wri(OFS_CTRL2, 32'hE, 1'b0);
		ce <= 1'b1;
	endtask
	task t_cyclic();
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, OFS_CYCSEL, i + 1);
			wait_pin(1'b0, 1'b0, 20, n);
			wait_pin(1'b0, 1'b1, 3000, n);
			wait_pin(1'b0, 1'b0, 20, w);
			chk(w, 8);
			wait_pin(1'b0, 1'b1, 3000, n);
			chk(w + n, 8 * tk[i]);
		end
		xfer(1'b1, OFS_CYCSEL, 32'h9);
		wait_pin(1'b0, 1'b1, 3000, n);
		rdchk(OFS_CTRL2, 32'h2, 32'h2);
		repeat (40) @(posedge core_clk);
		chk(irq.oe, 32'h1);
		wri(OFS_CTRL2, 32'hD, 1'b0);
		wait_pin(1'b0, 1'b1, 300, n);
		chk(n < 300, 32'h1);
		// Latched level flag must drop once the period select goes to zero
		xfer(1'b1, OFS_CYCSEL, 32'h0);
		@(posedge core_clk);
		chk(irq.oe, 32'h0);
		wait_pin(1'b0, 1'b1, 400, n);
		chk(n, 400);
	endtask
	task t_timer();
		xfer(1'b1, OFS_TIMER, 32'h8);
		repeat (3)
		begin
			xfer(1'b1, OFS_CTRL1, 32'h4);
			wait_pin(1'b1, 1'b1, 2000, n);
			chk(n, 2000);
		end
		xfer(1'b1, OFS_CTRL1, 32'h4);
		ce <= 1'b0;
		wait_pin(1'b1, 1'b1, 6000, n);
		chk(n, 6000);
		ce <= 1'b1;
		wait_pin(1'b1, 1'b1, 6000, n);
		chk(n < 6000, 32'h1);
		wait_pin(1'b1, 1'b0, 300, w);
		chk(w, 128);
		wait_pin(1'b1, 1'b1, 6000, n);
		chk(n inside {[3900:4300]}, 32'h1);
		xfer(1'b1, OFS_CTRL1, 32'h4);
		repeat (2) @(posedge core_clk);
		chk(tmr.oe, 32'h0);
	endtask
	task t_osc();
		rdchk(OFS_CTRL2, 32'h8, 32'h0);
		osc_run <= 1'b0;
		repeat (300) @(posedge core_clk);
		rdchk(OFS_CTRL2, 32'h8, 32'h8);
		rdchk(OFS_TIMER, 32'h8, 32'h0);
		osc_run <= 1'b1;
		repeat (100) @(posedge core_clk);
		rdchk(OFS_CTRL2, 32'h8, 32'h8);
	endtask
	initial
	begin
		resetn = 1'b0;
		osc_run = 1'b1;
		ce = 1'b1;
		carry = 1'b0;
		minute = 7'h05;
		hour = 6'h03;
		req = '0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_init();
		t_alarm();
		t_ce();
		t_cyclic();
		t_timer();
		t_osc();
		give_verdict();
	end
endmodule

// >>> bench/rtc_evt_asserts.sv
/*
 Port checker for rtc_event_block.
 Assumes a master that holds each request until pready.
*/
`timescale 1ns/1ps
module rtc_evt_asserts
	import rtc_evt_pkg::*;
#(
	parameter int OSC_STOP_CYC = OSC_STOP_CYC_DEF
)
(
	input wire logic     core_clk,
	input wire logic     resetn,
	input wire apb_req_t apb_req,
	input wire apb_rsp_t apb_rsp,
	input wire logic     chip_enable_pin,
	input wire od_pin_t  irq_pin_n,
	input wire od_pin_t  timer_pulse_pin,
	input wire logic     count_run_enable,
	input wire logic     count_chain_reset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic acc_w;
	logic chain_w;
	assign acc_w = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign chain_w = acc_w && apb_req.paddr == OFS_CTRL3 && apb_req.pwdata[2:0] == 3'h7;
	setup_answer_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	idle_quiet_a: assert property (!apb_req.psel |=> !apb_rsp.pready)
		else $error("pready without request");
	unmapped_err_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr ==
		(apb_req.paddr > OFS_TIMER || apb_req.paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	chain_pulse_a: assert property (count_chain_reset == $past(chain_w))
		else $error("chain reset pulse wrong");
	pins_drain_a: assert property (!irq_pin_n.out && !timer_pulse_pin.out)
		else $error("open drain pin driven high");
	restart_off_a: assert property (acc_w && apb_req.paddr == OFS_CTRL1 &&
		apb_req.pwdata[B_RESTART] |-> ##1 !timer_pulse_pin.oe)
		else $error("timer pin not released");
	ce_run_a: assert property (!chip_enable_pin [*6] |=> count_run_enable)
		else $error("run enable not forced");
endmodule
bind rtc_event_block rtc_evt_asserts #(.OSC_STOP_CYC(OSC_STOP_CYC)) rtc_evt_asserts_inst (
	.core_clk(core_clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.chip_enable_pin(chip_enable_pin), .irq_pin_n(irq_pin_n),
	.timer_pulse_pin(timer_pulse_pin), .count_run_enable(count_run_enable),
	.count_chain_reset(count_chain_reset));

// >>> verilog/rtc_event_block.sv
/*
 Event side of the real-time clock: alarm and cyclic interrupt on one open-drain
 pin, periodic timer pulse pin with restart, oscillator stop detector and the
 busy handshake of the count-chain reset, all behind an APB slave.
 Assumes the time counters sit outside and share core_clk; the oscillator and
 chip-enable pins are asynchronous.
*/
`timescale 1ns/1ps
module rtc_event_block
	import rtc_evt_pkg::*;
#(
	parameter int OSC_STOP_CYC = OSC_STOP_CYC_DEF
)
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire apb_req_t   apb_req,
	output apb_rsp_t        apb_rsp,
	input  wire logic       osc_in_pin,
	input  wire logic       chip_enable_pin,
	input  wire logic [6:0] cur_minute,
	input  wire logic [5:0] cur_hour,
	input  wire logic       carry_in,
	output od_pin_t         irq_pin_n,
	output od_pin_t         timer_pulse_pin,
	output logic            count_run_enable,
	output logic            count_chain_reset
);

	typedef struct packed {
		logic [2:0]   s_osc;
		logic [2:0]   s_ce;
		logic         osc_f;
		logic         ce_f;
		logic [15:0]  watch;
		logic         osc_run;
		logic [14:0]  div;
		logic [5:0]   sec;
		logic         match_q;
		logic         run;
		logic         alarm_arm_bit;
		logic         alarm_hit_flag;
		logic         periodic_hit_flag;
		logic         periodic_level_select;
		logic [2:0]   cyc_sel;
		logic [6:0]   alarm_min;
		logic [5:0]   alarm_hour;
		logic         test_disable_a;
		logic         test_disable_b;
		chain_state_t chain;
		logic         chain_pulse;
		logic         osc_stopped_flag;
		logic [2:0]   tmr_sel;
		logic         timer_output_enable;
		logic [16:0]  tmr_cnt;
		logic [4:0]   tmr_pulse;
		logic         irq_drive;
		logic         tmr_drive;
		logic         pin_level;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
	} state_t;

	localparam state_t ST_RST = '{
		s_osc:                 3'h0,
		s_ce:                  3'h0,
		osc_f:                 1'b0,
		ce_f:                  1'b0,
		watch:                 16'h0000,
		osc_run:               1'b0,
		div:                   15'h0000,
		sec:                   6'h00,
		match_q:               1'b0,
		run:                   RUN_RST,
		alarm_arm_bit:         1'b0,
		alarm_hit_flag:        1'b0,
		periodic_hit_flag:     1'b0,
		periodic_level_select: 1'b0,
		cyc_sel:               CYC_OFF,
		alarm_min:             7'h00,
		alarm_hour:            6'h00,
		test_disable_a:        1'b0,
		test_disable_b:        1'b0,
		chain:                 CHAIN_IDLE,
		chain_pulse:           1'b0,
		osc_stopped_flag:      OSCSTOP_RST,
		tmr_sel:               3'h0,
		timer_output_enable:   1'b0,
		tmr_cnt:               17'h00000,
		tmr_pulse:             5'h00,
		irq_drive:             1'b0,
		tmr_drive:             1'b0,
		pin_level:             1'b0,
		prdata:                32'h00000000,
		pready:                1'b0,
		pslverr:               1'b0
	};

	state_t q;
	state_t n;

	logic        osc_rise;
	logic        stop_evt;
	logic        sec_evt;
	logic        cyc_evt;
	logic        wr;
	logic        match;
	logic [31:0] rd;

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == OFS_CTRL1) || (addr == OFS_CTRL2) || (addr == OFS_CTRL3) ||
			(addr == OFS_CYCSEL) || (addr == OFS_ALARM) || (addr == OFS_TIMER);
	endfunction

	function automatic logic [14:0] period_mask(input logic [2:0] sel);
		unique case (sel)
			3'h1:    period_mask = MASK_P1;
			3'h2:    period_mask = MASK_P2;
			3'h3:    period_mask = MASK_P3;
			3'h4:    period_mask = MASK_P4;
			default: period_mask = MASK_P5;
		endcase
	endfunction

	always_comb
	begin
		n        = q;
		stop_evt = 1'b0;
		cyc_evt  = 1'b0;
		rd       = 32'h00000000;

		// Three-stage synchronisers, filtered on agreement of stages two and three
		n.s_osc = {q.s_osc[1:0], osc_in_pin};
		n.s_ce  = {q.s_ce[1:0], chip_enable_pin};
		if (q.s_osc[1] == q.s_osc[2])
		begin
			n.osc_f = q.s_osc[2];
		end
		if (q.s_ce[1] == q.s_ce[2])
		begin
			n.ce_f = q.s_ce[2];
		end
		osc_rise = (q.s_osc[1] == q.s_osc[2]) && q.s_osc[2] && !q.osc_f;

		// Stop detector: no oscillator edge for the whole watch window
		if (osc_rise)
		begin
			n.watch   = 16'h0000;
			n.osc_run = 1'b1;
		end
		else if (q.osc_run)
		begin
			if (q.watch == 16'(OSC_STOP_CYC - 1))
			begin
				stop_evt  = 1'b1;
				n.osc_run = 1'b0;
				n.watch   = 16'h0000;
			end
			else
			begin
				n.watch = q.watch + 16'h0001;
			end
		end

		// Divider chain of the 32.768 kHz timebase
		sec_evt = osc_rise && (q.div == MASK_P5);
		if (osc_rise)
		begin
			n.div = q.div + 15'h0001;
		end
		if (sec_evt)
		begin
			n.sec = (q.sec == SEC_LAST) ? 6'h00 : q.sec + 6'h01;
		end

		// Cyclic period event; select zero gives none
		if (q.cyc_sel == CYC_60S)
		begin
			cyc_evt = sec_evt && (q.sec == SEC_LAST);
		end
		else if (q.cyc_sel != CYC_OFF && q.cyc_sel < CYC_60S)
		begin
			cyc_evt = osc_rise && ((q.div & period_mask(q.cyc_sel)) ==
				period_mask(q.cyc_sel));
		end

		// Register read, captured in the setup phase
		unique case (apb_req.paddr)
			OFS_CTRL1:
			begin
				rd[B_RUN] = q.run;
				rd[B_ARM] = q.alarm_arm_bit;
			end
			OFS_CTRL2:
			begin
				rd[B_ALFLAG]  = q.alarm_hit_flag;
				rd[B_CYFLAG]  = q.periodic_hit_flag;
				rd[B_BUSY]    = (q.chain == CHAIN_WAIT);
				rd[B_OSCSTOP] = q.osc_stopped_flag;
			end
			OFS_CTRL3:
			begin
				rd[B_TESTA] = q.test_disable_a;
				rd[B_TESTB] = q.test_disable_b;
			end
			OFS_CYCSEL:
			begin
				rd[2:0]     = q.cyc_sel;
				rd[B_LEVEL] = q.periodic_level_select;
			end
			OFS_ALARM:
			begin
				rd[6:0]                     = q.alarm_min;
				rd[F_HOUR_LSB+5:F_HOUR_LSB] = q.alarm_hour;
			end
			OFS_TIMER:
			begin
				rd[2:0]      = q.tmr_sel;
				rd[B_TMR_OE] = q.timer_output_enable;
			end
			default:
			begin
				rd = 32'h00000000;
			end
		endcase

		// Zero-wait slave: pready rises in the access phase
		n.pready  = apb_req.psel && !apb_req.penable;
		n.pslverr = apb_req.psel && !apb_req.penable && !is_mapped(apb_req.paddr);
		n.prdata  = (apb_req.psel && !apb_req.penable) ? rd : 32'h00000000;
		wr = apb_req.psel && apb_req.penable && apb_req.pwrite && q.pready &&
			is_mapped(apb_req.paddr);

		n.chain_pulse = 1'b0;

		// Clears first, hardware sets afterwards so a coinciding set wins
		if (q.chain == CHAIN_WAIT && q.osc_run && !carry_in)
		begin
			n.chain = CHAIN_IDLE;
		end
		if (!q.periodic_level_select && osc_rise)
		begin
			n.periodic_hit_flag = 1'b0;
		end
		if (q.cyc_sel == CYC_OFF)
		begin
			n.periodic_hit_flag = 1'b0;
		end

		if (wr)
		begin
			unique case (apb_req.paddr)
				OFS_CTRL1:
				begin
					n.run           = apb_req.pwdata[B_RUN];
					n.alarm_arm_bit = apb_req.pwdata[B_ARM];
					if (apb_req.pwdata[B_RESTART])
					begin
						n.tmr_cnt   = 17'h00000;
						n.tmr_pulse = 5'h00;
					end
				end
				OFS_CTRL2:
				begin
					// Flags clear on a written 0, the cyclic flag only in level mode; a written 1 is ignored
					if (!apb_req.pwdata[B_ALFLAG])
					begin
						n.alarm_hit_flag = 1'b0;
					end
					if (!apb_req.pwdata[B_CYFLAG] && q.periodic_level_select)
					begin
						n.periodic_hit_flag = 1'b0;
					end
					if (!apb_req.pwdata[B_OSCSTOP])
					begin
						n.osc_stopped_flag = 1'b0;
					end
				end
				OFS_CTRL3:
				begin
					n.test_disable_a = apb_req.pwdata[B_TESTA];
					n.test_disable_b = apb_req.pwdata[B_TESTB];
					if (apb_req.pwdata[B_TESTA] && apb_req.pwdata[B_TESTB] &&
						apb_req.pwdata[B_CHAIN])
					begin
						n.chain       = CHAIN_WAIT;
						n.chain_pulse = 1'b1;
					end
				end
				OFS_CYCSEL:
				begin
					n.cyc_sel               = apb_req.pwdata[2:0];
					n.periodic_level_select = apb_req.pwdata[B_LEVEL];
				end
				OFS_ALARM:
				begin
					n.alarm_min  = apb_req.pwdata[6:0];
					n.alarm_hour = apb_req.pwdata[F_HOUR_LSB+5:F_HOUR_LSB];
				end
				OFS_TIMER:
				begin
					n.tmr_sel             = apb_req.pwdata[2:0];
					n.timer_output_enable = apb_req.pwdata[B_TMR_OE];
				end
				default:
				begin
					n.run = q.run;
				end
			endcase
		end

		// Chip enable low forces the count on
		if (!q.ce_f)
		begin
			n.run = 1'b1;
		end

		// Alarm: edge of equality so a cleared flag does not refire in the same minute
		match     = (cur_minute == q.alarm_min) && (cur_hour == q.alarm_hour);
		n.match_q = match;
		if (q.alarm_arm_bit && match && !q.match_q)
		begin
			n.alarm_hit_flag = 1'b1;
		end

		// Cyclic set, independent of chip enable
		if (cyc_evt)
		begin
			n.periodic_hit_flag = 1'b1;
		end

		// Timer counts only while chip enable is high; restart takes precedence
		if (!(wr && apb_req.paddr == OFS_CTRL1 && apb_req.pwdata[B_RESTART]) &&
			osc_rise && q.ce_f)
		begin
			if (q.tmr_pulse != 5'h00)
			begin
				n.tmr_pulse = q.tmr_pulse - 5'h01;
			end
			if (q.tmr_cnt == (TMR_BASE_TICKS << q.tmr_sel) - 17'h00001)
			begin
				n.tmr_cnt   = 17'h00000;
				n.tmr_pulse = TMR_PULSE_TICKS;
			end
			else
			begin
				n.tmr_cnt = q.tmr_cnt + 17'h00001;
			end
		end

		if (stop_evt)
		begin
			n.osc_stopped_flag    = 1'b1;
			n.timer_output_enable = 1'b0;
		end

		// Open-drain drives: enable high pulls the wire low
		n.irq_drive = (n.alarm_arm_bit && n.alarm_hit_flag) || n.periodic_hit_flag;
		n.tmr_drive = n.timer_output_enable && (n.tmr_pulse != 5'h00);
		n.pin_level = 1'b0;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			q <= ST_RST;
		end
		else
		begin
			q <= n;
		end
	end

	assign apb_rsp.prdata      = q.prdata;
	assign apb_rsp.pready      = q.pready;
	assign apb_rsp.pslverr     = q.pslverr;
	assign irq_pin_n.out       = q.pin_level;
	assign irq_pin_n.oe        = q.irq_drive;
	assign timer_pulse_pin.out = q.pin_level;
	assign timer_pulse_pin.oe  = q.tmr_drive;
	assign count_run_enable    = q.run;
	assign count_chain_reset   = q.chain_pulse;

endmodule

// >>> verilog/rtc_evt_pkg.sv
/*
 Constants, field layout and carrier types for the real-time clock event block:
 alarm and cyclic interrupt, periodic timer pulse, oscillator stop detector.
 Assumes a 50 MHz core clock and an APB master with 32-bit data.
*/
// Functional notes
// - Alarm minutes and hours match pulls irq low
// - Alarm flag reads 1 while alarm pulls low
// - Arm bit or alarm flag can release pin
// - Six cyclic periods from oscillator divider chain
// - Pulse mode: cyclic pulses, host never writes flag
// - Level mode: low until host writes flag 0
// - Period select zero cancels cyclic interrupts
// - Cyclic flag reads 1 while cyclic pulls low
// - Timer pin pulses every selected interval
// - Timer restart clears counter, acts as watchdog
// - Restart during pulse releases timer pin now
// - Timer halts while chip enable is low
// - Oscillator stop clears timer output enable
// - Oscillator stop sets stop flag to 1
// - Stop flag is 1 after power-up
// - Stop flag sticks until software clears it
// - Test bits plus chain reset set busy
// - Busy holds until oscillation runs, no carry
// - Count enable 0 stops counting; host releases pins
// - Irq pin is OR of alarm and cyclic
// - Interrupts work with chip enable high or low
// - Chip enable low forces count enable to 1
package rtc_evt_pkg;

	localparam int CLK_MHZ          = 50;
	localparam int OSC_STOP_NS      = 122100;
	localparam int OSC_STOP_CYC_DEF = (OSC_STOP_NS * CLK_MHZ + 999) / 1000;

	localparam logic [7:0] OFS_CTRL1  = 8'h00;
	localparam logic [7:0] OFS_CTRL2  = 8'h04;
	localparam logic [7:0] OFS_CTRL3  = 8'h08;
	localparam logic [7:0] OFS_CYCSEL = 8'h0C;
	localparam logic [7:0] OFS_ALARM  = 8'h10;
	localparam logic [7:0] OFS_TIMER  = 8'h14;

	localparam int B_RUN      = 0;
	localparam int B_ARM      = 1;
	localparam int B_RESTART  = 2;
	localparam int B_ALFLAG   = 0;
	localparam int B_CYFLAG   = 1;
	localparam int B_BUSY     = 2;
	localparam int B_OSCSTOP  = 3;
	localparam int B_TESTA    = 0;
	localparam int B_TESTB    = 1;
	localparam int B_CHAIN    = 2;
	localparam int B_LEVEL    = 3;
	localparam int B_TMR_OE   = 3;
	localparam int F_HOUR_LSB = 8;

	localparam logic RUN_RST     = 1'b1;
	localparam logic OSCSTOP_RST = 1'b1;

	localparam logic [2:0] CYC_OFF = 3'h0;
	localparam logic [2:0] CYC_60S = 3'h6;
	localparam logic [14:0] MASK_P1 = 15'h000F;
	localparam logic [14:0] MASK_P2 = 15'h001F;
	localparam logic [14:0] MASK_P3 = 15'h00FF;
	localparam logic [14:0] MASK_P4 = 15'h07FF;
	localparam logic [14:0] MASK_P5 = 15'h7FFF;
	localparam logic [5:0]  SEC_LAST = 6'h3B;

	localparam logic [16:0] TMR_BASE_TICKS  = 17'h00200;
	localparam logic [4:0]  TMR_PULSE_TICKS = 5'h10;

	typedef enum logic [0:0] {CHAIN_IDLE = 1'b0, CHAIN_WAIT = 1'b1} chain_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

endpackage
